/* File: rtl/bank_cmd_if.sv */
/*
 * Decoded per-bank command strobes from the command decoder to the banks.
 * Assumes all strobes are single-cycle and on the device clock.
 */
`timescale 1ns/1ps
interface bank_cmd_if;
    import sdram_pkg::*;
    logic             activate;
    logic             precharge;
    logic             pre_all;
    logic             read;
    logic             write;
    logic             auto_pre;
    logic             burst_end;
    logic [1:0]       bank;
    logic [1:0]       end_bank;
    logic [ROW_W-1:0] row;
    modport ctrl (output activate, precharge, pre_all, read, write, auto_pre, burst_end, bank, end_bank, row);
    modport sink (input  activate, precharge, pre_all, read, write, auto_pre, burst_end, bank, end_bank, row);
endinterface

/* File: rtl/bank_fsm.sv */
/*
 * One bank: open-row tracking, activate and precharge timing, auto precharge.
 * Assumes commands arrive already decoded and gated from the command decoder.
 */
`timescale 1ns/1ps
module bank_fsm import sdram_pkg::*; #(
    parameter logic [1:0] ID = 2'h0
) (
    input  wire logic           clock,
    input  wire logic           rst,
    bank_cmd_if.sink            cmd,
    output bank_state_e         state,
    output logic [ROW_W-1:0]    row
);
    bank_state_e      state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             ap_q;
    logic             hit;
    logic             pre_hit;
    logic             end_hit;

    assign hit     = cmd.bank == ID;
    assign pre_hit = cmd.precharge & (cmd.pre_all | hit);
    assign end_hit = cmd.burst_end & (cmd.end_bank == ID);
    assign state   = state_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= BANK_IDLE;
            cnt_q   <= '0;
            ap_q    <= 1'b0;
        end else begin
            unique case (state_q)
                BANK_IDLE: begin
                    if (cmd.activate & hit) begin
                        state_q <= BANK_ACTIVATING;
                        cnt_q   <= CNT_W'(RCD_CYC - 1);
                    end
                end
                BANK_ACTIVATING: begin
                    if (cnt_q == '0) state_q <= BANK_ROW_ACTIVE;
                    else cnt_q <= cnt_q - CNT_W'(1);
                end
                BANK_ROW_ACTIVE, BANK_READING, BANK_WRITING: begin
                    if (pre_hit) begin
                        state_q <= BANK_PRECHARGING;
                        cnt_q   <= CNT_W'(RP_CYC - 1);
                    end else if ((cmd.read | cmd.write) & hit) begin
                        state_q <= cmd.read ? BANK_READING : BANK_WRITING;
                        ap_q    <= cmd.auto_pre;
                    end else if (state_q != BANK_ROW_ACTIVE
                                 & (end_hit | cmd.read | cmd.write)) begin
                        // burst finished, stopped, or overtaken by another bank
                        state_q <= ap_q ? BANK_PRECHARGING : BANK_ROW_ACTIVE;
                        cnt_q   <= CNT_W'(RP_CYC - 1);
                        ap_q    <= 1'b0;
                    end
                end
                BANK_PRECHARGING: begin
                    if (cnt_q == '0) state_q <= BANK_IDLE;
                    else cnt_q <= cnt_q - CNT_W'(1);
                end
                default: state_q <= BANK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) row <= '0;
        else if (cmd.activate & hit & state_q == BANK_IDLE) row <= cmd.row;
    end

    sequence s_open;
        cmd.activate && hit && state_q == BANK_IDLE;
    endsequence
    sequence s_close;
        pre_hit && state_q == BANK_ROW_ACTIVE;
    endsequence

    a_rcd_wait: assert property (@(posedge clock) disable iff (rst)
        s_open |=> (state_q == BANK_ACTIVATING)[*2] ##1 state_q == BANK_ROW_ACTIVE)
        else $error("bank did not open after activate delay");
    a_rp_wait: assert property (@(posedge clock) disable iff (rst)
        s_close |=> (state_q == BANK_PRECHARGING)[*2] ##1 state_q == BANK_IDLE)
        else $error("bank did not close after precharge delay");
    a_row_capture: assert property (@(posedge clock) disable iff (rst)
        s_open |=> row == $past(cmd.row))
        else $error("row not captured on activate");
    a_auto_close: assert property (@(posedge clock) disable iff (rst)
        (end_hit && ap_q && !pre_hit && !((cmd.read | cmd.write) && hit)
         && (state_q == BANK_READING || state_q == BANK_WRITING))
        |=> state_q == BANK_PRECHARGING)
        else $error("auto precharge not started at burst end");
endmodule

/* File: rtl/burst_gen.sv */
/*
 * Column address generator for one burst, sequential or interleaved order.
 * Assumes start and stop are never raised in the same cycle.
 */
`timescale 1ns/1ps
module burst_gen import sdram_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic             interleave,
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [2:0]       bl_code,
    output logic [COL_W-1:0]      col,
    output logic                  beat,
    output logic                  ending
);
    logic [COL_W-1:0] base_q;
    logic [COL_W-1:0] cnt_q;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] offs;
    logic             active_q;
    logic             full;
    logic             last;

    assign full   = bl_code == BL_FULL;
    assign mask   = full ? {COL_W{1'b1}} : (COL_W'(1) << bl_code[1:0]) - COL_W'(1);
    assign offs   = interleave ? (base_q ^ cnt_q) : (base_q + cnt_q);
    assign col    = start ? start_col : ((base_q & ~mask) | (offs & mask));
    assign last   = (cnt_q == mask) & ~full;
    assign beat   = start | (active_q & ~stop);
    assign ending = (active_q & ~start & (stop | last)) | (start & (mask == '0));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_q   <= '0;
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else if (start) begin
            base_q   <= start_col;
            cnt_q    <= COL_W'(1);
            active_q <= mask != '0;
        end else if (active_q) begin
            if (stop | last) active_q <= 1'b0;
            cnt_q <= cnt_q + COL_W'(1);
        end
    end
endmodule

/* File: rtl/sdram_command_interface.sv */
/*
 * Command interface of a four-bank synchronous DRAM: decode, bank control,
 * burst addressing, byte masks, refresh and low-power states.
 * Assumes the controller shares this clock; the array sits outside on acc_*.
 */
`timescale 1ns/1ps
module sdram_command_interface import sdram_pkg::*; (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic              bank_select_0,
    input  wire logic              bank_select_1,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [MASK_W-1:0] dqm,
    input  wire logic [DQ_W-1:0]   dq_in,
    input  wire logic [DQ_W-1:0]   arr_rdata,
    output logic [DQ_W-1:0]        dq_out,
    output logic [MASK_W-1:0]      dq_oe_n,
    output logic                   acc_valid,
    output logic                   acc_write,
    output logic [1:0]             acc_bank,
    output logic [ROW_W-1:0]       acc_row,
    output logic [COL_W-1:0]       acc_col,
    output logic [DQ_W-1:0]        acc_wdata,
    output logic [MASK_W-1:0]      acc_wmask,
    output logic                   refresh_strobe,
    output logic [ROW_W-1:0]       refresh_row,
    output logic [MODE_W-1:0]      mode_reg,
    output logic [NBANK-1:0]       bank_open,
    output logic                   self_refresh,
    output logic                   deep_sleep
);
    bank_cmd_if bcmd ();

    bank_state_e      bank_state [NBANK];
    logic [ROW_W-1:0] bank_row [NBANK];
    logic [1:0]       bsel;
    logic [2:0]       op;
    logic             busy;
    logic             live;
    logic             is_act;
    logic             is_read;
    logic             is_write;
    logic             is_bt;
    logic             is_dsleep;
    logic             is_pre;
    logic             is_ref;
    logic             is_sref;
    logic             is_mode;
    logic             rw_start;
    logic             gen_stop;
    logic [COL_W-1:0] gen_col;
    logic             gen_beat;
    logic             gen_end;
    logic [1:0]       burst_bank_q;
    logic             burst_wr_q;
    logic             end_q;
    logic [1:0]       end_bank_q;
    logic [MODE_W-1:0] mode_q;
    logic [CNT_W-1:0] ref_cnt_q;
    logic [ROW_W-1:0] ref_row_q;
    logic             self_q;
    logic             dsleep_q;
    logic [MASK_W-1:0] dqm_q1;
    logic [MASK_W-1:0] dqm_q2;
    logic             rdv_q;
    logic [DQ_W-1:0]  rdata_q;

    // decode, everything sampled at the rising edge
    assign bsel      = {bank_select_1, bank_select_0};
    assign op        = {ras_n, cas_n, we_n};
    assign busy      = self_q | dsleep_q | (ref_cnt_q != '0);
    assign live      = ~cs_n & ~busy;
    assign is_act    = live & cke & (op == OP_ACT);
    assign is_read   = live & cke & (op == OP_READ);
    assign is_write  = live & cke & (op == OP_WRITE);
    assign is_pre    = live & cke & (op == OP_PRE);
    assign is_mode   = live & cke & (op == OP_MODE);
    assign is_ref    = live & cke & (op == OP_REF);
    assign is_sref   = live & ~cke & (op == OP_REF);
    assign is_bt     = live & cke & (op == OP_BT);
    assign is_dsleep = live & ~cke & (op == OP_BT);
    assign rw_start  = is_read | is_write;

    // terminate or a precharge of the bursting bank stops the current burst
    assign gen_stop = is_bt | (is_pre & (addr[AP_BIT] | bsel == burst_bank_q));

    assign bcmd.activate  = is_act;
    assign bcmd.precharge = is_pre;
    assign bcmd.pre_all   = addr[AP_BIT];
    assign bcmd.read      = is_read;
    assign bcmd.write     = is_write;
    assign bcmd.auto_pre  = addr[AP_BIT];
    assign bcmd.bank      = bsel;
    assign bcmd.row       = addr[ROW_W-1:0];
    assign bcmd.burst_end = end_q;
    assign bcmd.end_bank  = end_bank_q;

    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            bank_fsm #(
                .ID (2'(b))
            ) u_bank (
                .clock (clock),
                .rst   (rst),
                .cmd   (bcmd),
                .state (bank_state[b]),
                .row   (bank_row[b])
            );
            assign bank_open[b] = bank_state[b] != BANK_IDLE
                                  && bank_state[b] != BANK_PRECHARGING;
        end
    endgenerate

    burst_gen u_burst (
        .clock      (clock),
        .rst        (rst),
        .start      (rw_start),
        .stop       (gen_stop),
        .interleave (mode_q[MODE_ORDER_BIT]),
        .start_col  (addr[COL_W-1:0]),
        .bl_code    (mode_q[MODE_BL_LSB +: 3]),
        .col        (gen_col),
        .beat       (gen_beat),
        .ending     (gen_end)
    );

    // burst ownership and end notification to the banks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            burst_bank_q <= '0;
            burst_wr_q   <= 1'b0;
            end_q        <= 1'b0;
            end_bank_q   <= '0;
        end else begin
            if (rw_start) begin
                burst_bank_q <= bsel;
                burst_wr_q   <= is_write;
            end
            end_q      <= gen_end;
            end_bank_q <= rw_start ? bsel : burst_bank_q;
        end
    end

    // array access, write data and mask taken on the same edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_valid <= 1'b0;
            acc_write <= 1'b0;
            acc_bank  <= '0;
            acc_row   <= '0;
            acc_col   <= '0;
            acc_wdata <= '0;
            acc_wmask <= '0;
        end else begin
            acc_valid <= gen_beat;
            acc_write <= rw_start ? is_write : burst_wr_q;
            acc_bank  <= rw_start ? bsel : burst_bank_q;
            acc_row   <= bank_row[rw_start ? bsel : burst_bank_q];
            acc_col   <= gen_col;
            acc_wdata <= dq_in;
            acc_wmask <= dqm;
        end
    end

    // read path: data and its mask come out two clocks after the mask edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dqm_q1  <= '0;
            dqm_q2  <= '0;
            rdv_q   <= 1'b0;
            rdata_q <= '0;
            dq_out  <= '0;
            dq_oe_n <= '1;
        end else begin
            dqm_q1  <= dqm;
            dqm_q2  <= dqm_q1;
            rdv_q   <= acc_valid & ~acc_write;
            rdata_q <= arr_rdata;
            dq_out  <= rdata_q;
            dq_oe_n <= ~({MASK_W{rdv_q}} & ~dqm_q2);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) mode_q <= MODE_RESET;
        else if (is_mode) mode_q <= addr[MODE_W-1:0];
    end
    assign mode_reg = mode_q;

    // refresh row counter and busy window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_cnt_q      <= '0;
            ref_row_q      <= '0;
            refresh_strobe <= 1'b0;
        end else begin
            refresh_strobe <= is_ref;
            if (is_ref) begin
                ref_row_q <= ref_row_q + ROW_W'(1);
                ref_cnt_q <= CNT_W'(RFC_CYC - 1);
            end else if (self_q & cke) begin
                ref_cnt_q <= CNT_W'(RFC_CYC - 1);
            end else if (ref_cnt_q != '0) begin
                ref_cnt_q <= ref_cnt_q - CNT_W'(1);
            end
        end
    end
    assign refresh_row = ref_row_q;

    // low-power states, left as soon as clock enable returns high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            self_q   <= 1'b0;
            dsleep_q <= 1'b0;
        end else begin
            if (is_sref) self_q <= 1'b1;
            else if (cke) self_q <= 1'b0;
            if (is_dsleep) dsleep_q <= 1'b1;
            else if (cke) dsleep_q <= 1'b0;
        end
    end
    assign self_refresh = self_q;
    assign deep_sleep   = dsleep_q;

    sequence s_read_beat;
        acc_valid && !acc_write;
    endsequence

    a_read_mask: assert property (@(posedge clock) disable iff (rst)
        s_read_beat |=> ##1 dq_oe_n == $past(dqm, 3))
        else $error("read mask not applied two clocks later");
    a_write_mask: assert property (@(posedge clock) disable iff (rst)
        is_write |=> acc_valid && acc_write && acc_wmask == $past(dqm))
        else $error("write mask not applied with the data");
    a_mode_load: assert property (@(posedge clock) disable iff (rst)
        is_mode |=> mode_q == $past(addr[MODE_W-1:0]))
        else $error("mode register not loaded");
    a_start_col: assert property (@(posedge clock) disable iff (rst)
        rw_start |=> acc_col == $past(addr[COL_W-1:0]) && acc_bank == $past(bsel))
        else $error("burst start column wrong");
    a_deselect_hold: assert property (@(posedge clock) disable iff (rst)
        cs_n && !gen_beat |=> !acc_valid && $stable(mode_q) && $stable(ref_row_q))
        else $error("deselected device acted");
    a_refresh_row: assert property (@(posedge clock) disable iff (rst)
        is_ref |=> ref_row_q == $past(ref_row_q) + ROW_W'(1) ##1 busy)
        else $error("refresh counter or busy window wrong");
    // low-power entry and exit, the refresh pulse, no-operation hold and terminate
    sequence s_self_enter;
        is_sref;
    endsequence
    sequence s_self_leave;
        self_q && cke;
    endsequence

    a_self_enter: assert property (@(posedge clock) disable iff (rst)
        s_self_enter |=> self_q)
        else $error("self refresh not entered");
    a_self_leave: assert property (@(posedge clock) disable iff (rst)
        s_self_leave |=> !self_q ##1 busy)
        else $error("self refresh not left on clock enable");
    a_ref_pulse: assert property (@(posedge clock) disable iff (rst)
        is_ref |=> refresh_strobe ##1 !refresh_strobe)
        else $error("refresh strobe not a single pulse");
    a_nop_hold: assert property (@(posedge clock) disable iff (rst)
        live && op == OP_NOP && !gen_beat |=> !acc_valid && $stable(mode_q) && $stable(ref_row_q))
        else $error("no-operation changed state");
    a_sleep_exit: assert property (@(posedge clock) disable iff (rst)
        dsleep_q && cke |=> !dsleep_q && !acc_valid)
        else $error("deep sleep not left on clock enable");
    a_bt_stop: assert property (@(posedge clock) disable iff (rst)
        is_bt |=> !acc_valid)
        else $error("burst not truncated by terminate");
endmodule

/* File: rtl/sdram_pkg.sv */
/*
 * Shared constants and types for the synchronous DRAM command interface.
 * Assumes a single 100 MHz clock shared with the memory controller.
 */
package sdram_pkg;
    localparam int ROW_W         = 13;
    localparam int COL_W         = 10;
    localparam int ADDR_W        = 13;
    localparam int DQ_W          = 16;
    localparam int MASK_W        = 2;
    localparam int NBANK         = 4;
    localparam int MODE_W        = 12;
    localparam int AP_BIT        = 10;
    localparam int CNT_W         = 8;

    localparam int CLK_PERIOD_PS = 10000;
    localparam int T_RCD_NS      = 20;
    localparam int T_RP_NS       = 20;
    localparam int T_RFC_NS      = 80;
    localparam int RCD_CYC       = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RP_CYC        = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RFC_CYC       = (T_RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // mode register fields
    localparam int MODE_BL_LSB    = 0;
    localparam int MODE_ORDER_BIT = 3;
    localparam logic [2:0]        BL_FULL    = 3'h7;
    localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;

    // {row strobe, column strobe, write strobe}, all active low
    localparam logic [2:0] OP_NOP   = 3'h7;
    localparam logic [2:0] OP_ACT   = 3'h3;
    localparam logic [2:0] OP_READ  = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_BT    = 3'h6;
    localparam logic [2:0] OP_PRE   = 3'h2;
    localparam logic [2:0] OP_REF   = 3'h1;
    localparam logic [2:0] OP_MODE  = 3'h0;

    typedef enum logic [5:0] {
        BANK_IDLE        = 6'h01,
        BANK_ACTIVATING  = 6'h02,
        BANK_ROW_ACTIVE  = 6'h04,
        BANK_READING     = 6'h08,
        BANK_WRITING     = 6'h10,
        BANK_PRECHARGING = 6'h20
    } bank_state_e;
endpackage

/* File: verif/array_model.sv */
/*
 * Behavioural memory array behind the command interface.
 * Assumes the device wants read data combinationally from this cycle's acc_* address.
 */
`timescale 1ns/1ps
module array_model import sdram_pkg::*; (
    input  wire logic [1:0]       acc_bank,
    input  wire logic [ROW_W-1:0] acc_row,
    input  wire logic [COL_W-1:0] acc_col,
    output logic [DQ_W-1:0]       arr_rdata
);
    // pattern unique per bank, column and low four row bits
    assign arr_rdata = {acc_bank, acc_row[3:0], acc_col} ^ 16'h5a00;
endmodule

/* File: verif/sdram_command_interface_tb_top.sv */
/*
 * Self-checking bench for the command interface: decode, bursts, masks, banks, refresh, low power.
 * Assumes the array model answers acc_* combinationally and a 100 MHz clock.
 */
`timescale 1ns/1ps
module sdram_command_interface_tb_top;
    import sdram_pkg::*;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              cke = 1'b1;
    logic              cs_n = 1'b1;
    logic              ras_n = 1'b1;
    logic              cas_n = 1'b1;
    logic              we_n = 1'b1;
    logic              bank_select_0 = 1'b0;
    logic              bank_select_1 = 1'b0;
    logic [ADDR_W-1:0] addr = 13'h0000;
    logic [MASK_W-1:0] dqm = 2'h0;
    logic [DQ_W-1:0]   dq_in = 16'h0000;
    logic [DQ_W-1:0]   arr_rdata, dq_out, acc_wdata;
    logic [MASK_W-1:0] dq_oe_n, acc_wmask;
    logic              acc_valid, acc_write, refresh_strobe, self_refresh, deep_sleep;
    logic [1:0]        acc_bank;
    logic [ROW_W-1:0]  acc_row, refresh_row, old_row;
    logic [COL_W-1:0]  acc_col;
    logic [MODE_W-1:0] mode_reg;
    logic [NBANK-1:0]  bank_open;
    int                n_fail = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    sdram_command_interface dut (.clock(clock), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_select_0(bank_select_0), .bank_select_1(bank_select_1),
        .addr(addr), .dqm(dqm), .dq_in(dq_in), .arr_rdata(arr_rdata), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_bank(acc_bank), .acc_row(acc_row),
        .acc_col(acc_col), .acc_wdata(acc_wdata), .acc_wmask(acc_wmask), .refresh_strobe(refresh_strobe),
        .refresh_row(refresh_row), .mode_reg(mode_reg), .bank_open(bank_open),
        .self_refresh(self_refresh), .deep_sleep(deep_sleep));
    array_model array (.acc_bank(acc_bank), .acc_row(acc_row), .acc_col(acc_col), .arr_rdata(arr_rdata));

    always #5 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done;
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // waits one edge, command sampled at the edge after that, then NOP; returns 1 ns after that edge
    task automatic issue(input logic cs, input logic [2:0] op, input logic [1:0] bank,
                         input logic [12:0] a, input logic [1:0] m, input logic [15:0] d, input logic ck);
        idle(1);
        cs_n = cs;
        {ras_n, cas_n, we_n} = op;
        {bank_select_1, bank_select_0} = bank;
        addr = a;
        dqm = m;
        dq_in = d;
        cke = ck;
        idle(1);
        {ras_n, cas_n, we_n} = OP_NOP;
        dqm = 2'h0;
    endtask

    function automatic logic [15:0] rd_exp(input logic [1:0] b, input logic [12:0] r, input logic [9:0] c);
        return {b, r[3:0], c} ^ 16'h5a00;
    endfunction

    initial begin
        idle(2);
        rst = 1'b0;
        check(dq_oe_n, 2'h3);
        issue(1'b1, OP_MODE, 2'h0, 13'h0021, 2'h0, 16'h0, 1'b1);
        check(mode_reg, 12'h000);
        issue(1'b0, OP_MODE, 2'h0, 13'h1001, 2'h0, 16'h0, 1'b1);
        check(mode_reg, 12'h001);
        $display("mode load test done");
        issue(1'b0, OP_ACT, 2'h2, 13'h0abc, 2'h0, 16'h0, 1'b1);
        check(bank_open, 4'h4);
        idle(2);
        issue(1'b0, OP_WRITE, 2'h2, 13'h0005, 2'h2, 16'h1234, 1'b1);
        check({acc_valid, acc_write, acc_bank, acc_row, acc_col}, {2'h3, 2'h2, 13'h0abc, 10'h005});
        check({acc_wdata, acc_wmask}, {16'h1234, 2'h2});
        idle(1);
        check(acc_col, 10'h004);
        issue(1'b0, OP_READ, 2'h2, 13'h0002, 2'h1, 16'h0, 1'b1);
        check({acc_valid, acc_write, acc_col}, {2'h2, 10'h002});
        idle(1);
        check(acc_col, 10'h003);
        idle(1);
        check({dq_oe_n, dq_out[15:8]}, {2'h1, 8'(rd_exp(2'h2, 13'h0abc, 10'h002) >> 8)});
        idle(1);
        check({dq_oe_n, dq_out}, {2'h0, rd_exp(2'h2, 13'h0abc, 10'h003)});
        $display("burst test done");
        issue(1'b0, OP_ACT, 2'h1, 13'h0005, 2'h0, 16'h0, 1'b1);
        idle(2);
        issue(1'b0, OP_PRE, 2'h2, 13'h0000, 2'h0, 16'h0, 1'b1);
        check(bank_open, 4'h2);
        issue(1'b0, OP_PRE, 2'h0, 13'h0400, 2'h0, 16'h0, 1'b1);
        check(bank_open, 4'h0);
        $display("precharge test done");
        idle(2);
        old_row = refresh_row;
        issue(1'b0, OP_REF, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b1);
        check(refresh_strobe, 1'b1);
        idle(8);
        check(refresh_row, old_row + 13'h0001);
        issue(1'b0, OP_REF, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0);
        check(self_refresh, 1'b1);
        issue(1'b0, OP_MODE, 2'h0, 13'h0002, 2'h0, 16'h0, 1'b0);
        check(mode_reg, 12'h001);
        cke = 1'b1;
        idle(1);
        check(self_refresh, 1'b0);
        idle(8);
        issue(1'b0, OP_BT, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0);
        check(deep_sleep, 1'b1);
        cke = 1'b1;
        idle(1);
        check(deep_sleep, 1'b0);
        $display("refresh and sleep test done");
        issue(1'b0, OP_MODE, 2'h0, 13'h000a, 2'h0, 16'h0, 1'b1);
        check(mode_reg, 12'h00a);
        issue(1'b0, OP_ACT, 2'h3, 13'h0123, 2'h0, 16'h0, 1'b1);
        idle(2);
        issue(1'b0, OP_READ, 2'h3, 13'h0405, 2'h0, 16'h0, 1'b1);
        check({acc_valid, acc_write, acc_row, acc_col}, {2'h2, 13'h0123, 10'h005});
        idle(1);
        check(acc_col, 10'h004);
        issue(1'b0, OP_BT, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b1);
        check(acc_valid, 1'b0);
        check(bank_open, 4'h8);
        idle(1);
        check(bank_open, 4'h0);
        idle(1);
        issue(1'b0, OP_ACT, 2'h3, 13'h0456, 2'h0, 16'h0, 1'b1);
        idle(2);
        issue(1'b0, OP_WRITE, 2'h3, 13'h0008, 2'h0, 16'h00ff, 1'b1);
        check({acc_row, acc_col}, {13'h0456, 10'h008});
        issue(1'b0, OP_WRITE, 2'h3, 13'h0010, 2'h0, 16'h00ff, 1'b1);
        check({acc_valid, acc_write, acc_col}, {2'h3, 10'h010});
        $display("auto precharge and terminate test done");
        test_done;
    end
endmodule
